// ### hdl/dus_uart.sv
// top: host bus decode and two serial channels with fifos and modem lines
// assumes: host bus inputs synchronous to clk_sys; data bus resolved outside
`timescale 1ns/100ps

module dus_uart #(
  parameter int FIFO_DEPTH = dus_pkg::FIFO_DEPTH
) (
  input  wire logic            clk_sys,
  input  wire logic            rst_b,
  input  wire dus_pkg::dus_bus_t hostIn,
  output logic      [7:0]      dataOut,
  output logic                 dataOe_n,
  input  wire logic            serialInA,
  input  wire logic            serialInB,
  output logic                 serialOutA,
  output logic                 serialOutB,
  input  wire logic            clearToSendA_n,
  input  wire logic            clearToSendB_n,
  input  wire logic            carrierDetectA_n,
  input  wire logic            carrierDetectB_n,
  output logic                 terminalReadyA_n,
  output logic                 terminalReadyB_n,
  output logic                 rxDmaRequestA,
  output logic                 rxDmaRequestB,
  output logic                 txDmaRequestA,
  output logic                 txDmaRequestB
);
  localparam int NC = dus_pkg::NUM_CH;
  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  generate
    if (FIFO_DEPTH != dus_pkg::FIFO_DEPTH)
    begin : g_bad
      $error("fifo depth must match the trigger level table");
    end
  endgenerate

  typedef struct packed {
    logic [7:0]          lcr;
    logic [7:0]          modem_control_reg;
    logic [7:0]          alt;
    logic [7:0]          dll;
    logic [7:0]          dlm;
    logic [7:0]          spr;
    logic                dmaMode;
    logic [1:0]          rxTrig;
    logic                overrun;
    logic [10:0]         txShift;
    logic [3:0]          txLeft;
    logic [3:0]          txPhase;
    dus_pkg::dus_rx_st_t rxSt;
    logic [3:0]          rxPhase;
    logic [3:0]          rxBits;
    logic [8:0]          rxShift;
    logic                txd;
    logic                dtr_n;
    logic                rxReq;
    logic                txReq;
  } dus_chan_t;

  typedef struct packed {
    dus_chan_t [NC-1:0] ch;
    logic               prevWr_n;
    logic               prevRd_n;
    logic [7:0]         dOut;
    logic               dOe_n;
  } dus_state_t;

  dus_state_t st_r;
  dus_state_t st_nxt;

  logic [NC-1:0]          tick;
  logic [NC-1:0]          serIn;
  logic [NC-1:0]          cts_n;
  logic [NC-1:0]          cd_n;
  logic [NC-1:0]          txPush;
  logic [NC-1:0]          txPop;
  logic [NC-1:0]          txClr;
  logic [NC-1:0]          rxPush;
  logic [NC-1:0]          rxPop;
  logic [NC-1:0]          rxClr;
  logic [NC-1:0]          txFull;
  logic [NC-1:0]          txEmpty;
  logic [NC-1:0]          rxFull;
  logic [NC-1:0]          rxEmpty;
  logic [NC-1:0][7:0]     txHead;
  logic [NC-1:0][9:0]     rxHead;
  logic [NC-1:0][9:0]     rxWData;
  logic [NC-1:0][CW-1:0]  txCount;
  logic [NC-1:0][CW-1:0]  rxCount;

  // channel A is index 0, channel B index 1
  assign serIn = {serialInB, serialInA};
  assign cts_n = {clearToSendB_n, clearToSendA_n};
  assign cd_n  = {carrierDetectB_n, carrierDetectA_n};

  assign dataOut          = st_r.dOut;
  assign dataOe_n         = st_r.dOe_n;
  assign serialOutA       = st_r.ch[0].txd;
  assign serialOutB       = st_r.ch[1].txd;
  assign terminalReadyA_n = st_r.ch[0].dtr_n;
  assign terminalReadyB_n = st_r.ch[1].dtr_n;
  assign rxDmaRequestA    = st_r.ch[0].rxReq;
  assign rxDmaRequestB    = st_r.ch[1].rxReq;
  assign txDmaRequestA    = st_r.ch[0].txReq;
  assign txDmaRequestB    = st_r.ch[1].txReq;

  ////////////////////////////////////////////////////////////////////////////
  // per-channel dividers and fifos
  generate
    for (genvar c = 0; c < NC; c++)
    begin : g_ch
      dus_baud #(.DW(dus_pkg::DIV_W)) u_baud (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .divisor ({st_r.ch[c].dlm, st_r.ch[c].dll}),
        .tick    (tick[c])
      );
      dus_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txf (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .clear    (txClr[c]),
        .push     (txPush[c]),
        .pushData (hostIn.wrData),
        .pop      (txPop[c]),
        .headData (txHead[c]),
        .count    (txCount[c]),
        .full     (txFull[c]),
        .empty    (txEmpty[c])
      );
      dus_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_rxf (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .clear    (rxClr[c]),
        .push     (rxPush[c]),
        .pushData (rxWData[c]),
        .pop      (rxPop[c]),
        .headData (rxHead[c]),
        .count    (rxCount[c]),
        .full     (rxFull[c]),
        .empty    (rxEmpty[c])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // frame builder: start, data, optional parity, stop
  function automatic logic [14:0] buildFrame(input logic [7:0] lcr, input logic [7:0] d);
    logic [10:0] f;
    logic [7:0]  md;
    logic [3:0]  n;
    logic        par;
    f   = '1;
    n   = 4'h5 + {2'b00, lcr[1:0]};
    md  = d & ~(8'hFF << n);
    par = lcr[dus_pkg::LCR_EPS] ? ^md : ~^md;
    f[0] = 1'b0;
    for (int k = 0; k < 8; k++)
      if (4'(k) < n)
        f[k+1] = md[k];
    if (lcr[dus_pkg::LCR_PEN])
      f[n+1] = par;
    return {n + 4'h2 + {3'b000, lcr[dus_pkg::LCR_PEN]}, f};
  endfunction : buildFrame

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic       sel;
    logic       wrStart;
    logic       rdStart;
    logic       hit;
    logic       dlab;
    logic       rxBit;
    logic       pe;
    logic [3:0] nBits;
    logic [3:0] need;
    logic [8:0] al;
    logic [7:0] rd;
    logic [14:0] fr;
    sel = 1'b0; wrStart = 1'b0; rdStart = 1'b0; hit = 1'b0; dlab = 1'b0;
    rxBit = 1'b0; pe = 1'b0; nBits = '0; need = '0; al = '0; rd = '0; fr = '0;
    st_nxt  = st_r;
    txPush  = '0;
    txPop   = '0;
    txClr   = '0;
    rxPush  = '0;
    rxPop   = '0;
    rxClr   = '0;
    rxWData = '0;
    st_nxt.prevWr_n = hostIn.cs_n | hostIn.wr_n;
    st_nxt.prevRd_n = hostIn.cs_n | hostIn.rd_n;
    wrStart = !hostIn.cs_n && !hostIn.wr_n && st_r.prevWr_n;
    rdStart = !hostIn.cs_n && !hostIn.rd_n && st_r.prevRd_n;
    st_nxt.dOe_n = hostIn.cs_n | hostIn.rd_n;
    sel = hostIn.channelPick ? 1'b0 : 1'b1;

    for (int i = 0; i < NC; i++)
    begin
      dlab = st_r.ch[i].lcr[dus_pkg::LCR_DLAB];
      // host writes
      hit = (sel == 1'(i)) || st_r.ch[0].alt[dus_pkg::ALT_BOTH]
            || st_r.ch[1].alt[dus_pkg::ALT_BOTH];
      if (wrStart && hit)
      begin
        case (hostIn.regPick)
          dus_pkg::REG_DATA:
            if (dlab)
              st_nxt.ch[i].dll = hostIn.wrData;
            else
              txPush[i] = 1'b1;
          dus_pkg::REG_DLM:
            if (dlab)
              st_nxt.ch[i].dlm = hostIn.wrData;
          dus_pkg::REG_FCR:
            if (dlab)
              st_nxt.ch[i].alt = hostIn.wrData;
            else
            begin
              rxClr[i]              = hostIn.wrData[dus_pkg::FCR_RXCL];
              txClr[i]              = hostIn.wrData[dus_pkg::FCR_TXCL];
              st_nxt.ch[i].dmaMode  = hostIn.wrData[dus_pkg::FCR_DMA];
              st_nxt.ch[i].rxTrig   = hostIn.wrData[dus_pkg::FCR_TRG +: 2];
            end
          dus_pkg::REG_LCR: st_nxt.ch[i].lcr = hostIn.wrData;
          dus_pkg::REG_MCR: st_nxt.ch[i].modem_control_reg = hostIn.wrData;
          dus_pkg::REG_SPR: st_nxt.ch[i].spr = hostIn.wrData;
          default: ;
        endcase
      end
      // host reads
      if (rdStart && sel == 1'(i))
      begin
        case (hostIn.regPick)
          dus_pkg::REG_DATA:
            if (dlab)
              rd = st_r.ch[i].dll;
            else
            begin
              rd       = rxHead[i][7:0];
              rxPop[i] = !rxEmpty[i];
            end
          dus_pkg::REG_DLM: rd = dlab ? st_r.ch[i].dlm : 8'h00;
          dus_pkg::REG_FCR: rd = dlab ? st_r.ch[i].alt : 8'h00;
          dus_pkg::REG_LCR: rd = st_r.ch[i].lcr;
          dus_pkg::REG_MCR: rd = st_r.ch[i].modem_control_reg;
          dus_pkg::REG_LSR:
          begin
            rd = {!rxEmpty[i] && (rxHead[i][9] || rxHead[i][8]),
                  txEmpty[i] && st_r.ch[i].txLeft == 4'h0, txEmpty[i], 1'b0,
                  !rxEmpty[i] && rxHead[i][9], !rxEmpty[i] && rxHead[i][8],
                  st_r.ch[i].overrun, !rxEmpty[i]};
            st_nxt.ch[i].overrun = 1'b0;
          end
          dus_pkg::REG_MSR:
          begin
            rd = 8'h00;
            rd[dus_pkg::MSR_CTS] = !cts_n[i];
            rd[dus_pkg::MSR_CD]  = !cd_n[i];
          end
          dus_pkg::REG_SPR: rd = st_r.ch[i].spr;
          default: rd = 8'h00;
        endcase
        st_nxt.dOut = rd;
      end

      // transmitter
      if (tick[i] && st_r.ch[i].txLeft != 4'h0)
      begin
        st_nxt.ch[i].txPhase = st_r.ch[i].txPhase + 4'h1;
        if (st_r.ch[i].txPhase == dus_pkg::OVS_LAST)
        begin
          st_nxt.ch[i].txShift = {1'b1, st_r.ch[i].txShift[10:1]};
          st_nxt.ch[i].txLeft  = st_r.ch[i].txLeft - 4'h1;
        end
      end
      else if (st_r.ch[i].txLeft == 4'h0 && !txEmpty[i]
               && (!cts_n[i] || st_r.ch[i].modem_control_reg[dus_pkg::MCR_LOOP]))
      begin
        fr = buildFrame(st_r.ch[i].lcr, txHead[i]);
        st_nxt.ch[i].txShift = fr[10:0];
        st_nxt.ch[i].txLeft  = fr[14:11];
        st_nxt.ch[i].txPhase = 4'h0;
        txPop[i]             = 1'b1;
      end
      // loopback holds the pin idle
      st_nxt.ch[i].txd = st_nxt.ch[i].modem_control_reg[dus_pkg::MCR_LOOP] ? 1'b1
                         : (st_nxt.ch[i].txLeft == 4'h0 ? 1'b1 : st_nxt.ch[i].txShift[0]);

      // receiver
      rxBit = st_r.ch[i].modem_control_reg[dus_pkg::MCR_LOOP] ?
              (st_r.ch[i].txLeft == 4'h0 ? 1'b1 : st_r.ch[i].txShift[0]) : serIn[i];
      nBits = 4'h5 + {2'b00, st_r.ch[i].lcr[1:0]};
      need  = nBits + {3'b000, st_r.ch[i].lcr[dus_pkg::LCR_PEN]};
      if (tick[i])
      begin
        st_nxt.ch[i].rxPhase = st_r.ch[i].rxPhase + 4'h1;
        case (st_r.ch[i].rxSt)
          dus_pkg::RX_IDLE:
          begin
            st_nxt.ch[i].rxPhase = 4'h0;
            if (!rxBit)
              st_nxt.ch[i].rxSt = dus_pkg::RX_START;
          end
          dus_pkg::RX_START:
            if (st_r.ch[i].rxPhase == dus_pkg::OVS_MID)
            begin
              st_nxt.ch[i].rxPhase = 4'h0;
              st_nxt.ch[i].rxBits  = 4'h0;
              st_nxt.ch[i].rxSt    = rxBit ? dus_pkg::RX_IDLE : dus_pkg::RX_DATA;
            end
          dus_pkg::RX_DATA:
            if (st_r.ch[i].rxPhase == dus_pkg::OVS_LAST)
            begin
              st_nxt.ch[i].rxShift = {rxBit, st_r.ch[i].rxShift[8:1]};
              st_nxt.ch[i].rxBits  = st_r.ch[i].rxBits + 4'h1;
              if (st_r.ch[i].rxBits + 4'h1 == need)
                st_nxt.ch[i].rxSt = dus_pkg::RX_STOP;
            end
          dus_pkg::RX_STOP:
            if (st_r.ch[i].rxPhase == dus_pkg::OVS_LAST)
            begin
              al = st_r.ch[i].rxShift >> (4'h9 - need);
              pe = st_r.ch[i].lcr[dus_pkg::LCR_PEN] &&
                   (al[nBits] != (st_r.ch[i].lcr[dus_pkg::LCR_EPS] ?
                    ^(al[7:0] & ~(8'hFF << nBits)) : ~^(al[7:0] & ~(8'hFF << nBits))));
              rxWData[i] = {!rxBit, pe, al[7:0] & ~(8'hFF << nBits)};
              rxPush[i]  = 1'b1;
              // a full fifo drops the char even when popped in this cycle
              if (rxFull[i])
                st_nxt.ch[i].overrun = 1'b1;
              st_nxt.ch[i].rxSt = dus_pkg::RX_IDLE;
            end
          default: st_nxt.ch[i].rxSt = dus_pkg::RX_IDLE;
        endcase
      end

      // modem and dma outputs
      st_nxt.ch[i].dtr_n = !st_nxt.ch[i].modem_control_reg[dus_pkg::MCR_DTR];
      st_nxt.ch[i].rxReq = st_r.ch[i].dmaMode ?
                           (rxCount[i] >= dus_pkg::RX_TRIG_LVL[st_r.ch[i].rxTrig]) :
                           !rxEmpty[i];
      st_nxt.ch[i].txReq = st_r.ch[i].dmaMode ?
                           (txCount[i] < dus_pkg::TX_DMA_LVL) : txEmpty[i];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r          <= '0;
      st_r.prevWr_n <= 1'b1;
      st_r.prevRd_n <= 1'b1;
      st_r.dOe_n    <= 1'b1;
      for (int i = 0; i < NC; i++)
      begin
        st_r.ch[i].lcr   <= dus_pkg::LCR_RST;
        st_r.ch[i].modem_control_reg   <= dus_pkg::MCR_RST;
        st_r.ch[i].alt   <= dus_pkg::ALT_RST;
        st_r.ch[i].dll   <= dus_pkg::DL_RST;
        st_r.ch[i].dlm   <= dus_pkg::DL_RST;
        st_r.ch[i].txd   <= 1'b1;
        st_r.ch[i].dtr_n <= 1'b1;
        st_r.ch[i].txReq <= 1'b1;
        st_r.ch[i].rxSt  <= dus_pkg::RX_IDLE;
      end
    end
    else
      st_r <= st_nxt;
  end

endmodule : dus_uart

// ### hdl/dus_pkg.sv
// package: constants and carrier types of the two-channel serial transceiver
// assumes: one 25 MHz clock, synchronous host bus inputs
package dus_pkg;

  localparam int NUM_CH     = 2;
  localparam int FIFO_DEPTH = 16;
  localparam int DIV_W      = 16;
  localparam int CNT_W      = 5;

  // register offsets on the three register-pick lines
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_DLM  = 3'h1;
  localparam logic [2:0] REG_FCR  = 3'h2;
  localparam logic [2:0] REG_ALT  = 3'h2;
  localparam logic [2:0] REG_LCR  = 3'h3;
  localparam logic [2:0] REG_MCR  = 3'h4;
  localparam logic [2:0] REG_LSR  = 3'h5;
  localparam logic [2:0] REG_MSR  = 3'h6;
  localparam logic [2:0] REG_SPR  = 3'h7;

  // field positions
  localparam int LCR_PEN  = 3;
  localparam int LCR_EPS  = 4;
  localparam int LCR_DLAB = 7;
  localparam int MCR_DTR  = 0;
  localparam int MCR_LOOP = 4;
  localparam int FCR_RXCL = 1;
  localparam int FCR_TXCL = 2;
  localparam int FCR_DMA  = 3;
  localparam int FCR_TRG  = 6;
  localparam int ALT_BOTH = 0;
  localparam int MSR_CTS  = 4;
  localparam int MSR_CD   = 7;

  // reset values
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] ALT_RST = 8'h00;
  localparam logic [7:0] DL_RST  = 8'h00;

  // oversampling and fifo levels
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID  = 4'h7;
  localparam logic [3:0][CNT_W-1:0] RX_TRIG_LVL = {5'h0E, 5'h08, 5'h04, 5'h01};
  localparam logic [CNT_W-1:0] TX_DMA_LVL = 5'h08;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'h0,
    RX_START = 2'h1,
    RX_DATA  = 2'h3,
    RX_STOP  = 2'h2
  } dus_rx_st_t;

  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       channelPick;
    logic [2:0] regPick;
    logic [7:0] wrData;
  } dus_bus_t;

endpackage : dus_pkg

// ### hdl/dus_fifo.sv
// single-clock fifo with clear, head visible without a pop
// assumes: caller never pops when empty; push when full is dropped
`timescale 1ns/100ps
module dus_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  input  wire logic                     clear,
  input  wire logic                     push,
  input  wire logic [WIDTH-1:0]         pushData,
  input  wire logic                     pop,
  output logic      [WIDTH-1:0]         headData,
  output logic      [$clog2(DEPTH):0]   count,
  output logic                          full,
  output logic                          empty
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad
      $error("fifo depth must be a power of two");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [AW:0]                 cnt;
  } dus_fifo_st_t;

  dus_fifo_st_t st_r;
  dus_fifo_st_t st_nxt;
  logic         doPush;
  logic         doPop;

  assign full     = st_r.cnt[AW];
  assign empty    = (st_r.cnt == '0);
  assign count    = st_r.cnt;
  assign headData = st_r.mem[st_r.rdPtr];

  always_comb
  begin
    st_nxt = st_r;
    doPush = push && !full;
    doPop  = pop && !empty;
    if (clear)
    begin
      st_nxt.wrPtr = '0;
      st_nxt.rdPtr = '0;
      st_nxt.cnt   = '0;
    end
    else
    begin
      if (doPush)
      begin
        st_nxt.mem[st_r.wrPtr] = pushData;
        st_nxt.wrPtr           = st_r.wrPtr + 1'b1;
      end
      if (doPop)
        st_nxt.rdPtr = st_r.rdPtr + 1'b1;
      st_nxt.cnt = st_r.cnt + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

endmodule : dus_fifo

// ### hdl/dus_baud.sv
// baud divider: one-cycle pulse at sixteen times the bit rate
// assumes: divisor of zero stops the pulses
`timescale 1ns/100ps
module dus_baud #(
  parameter int DW = 16
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire logic [DW-1:0] divisor,
  output logic               tick
);
  typedef struct packed {
    logic [DW-1:0] cnt;
    logic          tick;
  } dus_baud_st_t;

  dus_baud_st_t st_r;
  dus_baud_st_t st_nxt;

  assign tick = st_r.tick;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (divisor == '0)
      st_nxt.cnt = '0;
    else if (st_r.cnt <= DW'(1))
    begin
      st_nxt.cnt  = divisor;
      st_nxt.tick = 1'b1;
    end
    else
      st_nxt.cnt = st_r.cnt - 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

endmodule : dus_baud

// ### sim/dus_uart_checker.sv
// checker: port-level properties of the two-channel serial transceiver
// assumes: bound to dus_uart, one clock, asynchronous active-low reset
`timescale 1ns/100ps
module dus_uart_checker #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic              clk_sys,
  input wire logic              rst_b,
  input wire dus_pkg::dus_bus_t hostIn,
  input wire logic [7:0]        dataOut,
  input wire logic              dataOe_n,
  input wire logic              terminalReadyA_n,
  input wire logic              terminalReadyB_n,
  input wire logic              rxDmaRequestA,
  input wire logic              txDmaRequestA
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  logic rdIdle_r;
  logic wrIdle_r;
  logic rdGo;
  logic wrGo;
  logic mcrGo;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdIdle_r <= 1'b1;
      wrIdle_r <= 1'b1;
    end
    else
    begin
      rdIdle_r <= hostIn.cs_n | hostIn.rd_n;
      wrIdle_r <= hostIn.cs_n | hostIn.wr_n;
    end
  end
  assign rdGo  = rdIdle_r & ~hostIn.cs_n & ~hostIn.rd_n;
  assign wrGo  = wrIdle_r & ~hostIn.cs_n & ~hostIn.wr_n;
  assign mcrGo = wrGo & (hostIn.regPick == dus_pkg::REG_MCR);
  ////////////////////////////////////////////////////////////////////////////////
  a_read_drives_bus: assert property ((!hostIn.cs_n && !hostIn.rd_n) |=> !dataOe_n)
    else $error("data bus not driven during read");
  a_idle_read_released: assert property ((!hostIn.cs_n && hostIn.rd_n) |=> dataOe_n)
    else $error("data bus driven without read strobe");
  a_deselect_releases: assert property (hostIn.cs_n |=> dataOe_n)
    else $error("data bus driven while deselected");
  a_data_holds: assert property ((!rdGo && !$past(rdGo)) |=> $stable(dataOut))
    else $error("read data changed without a read");
  a_dtr_a_write: assert property ((mcrGo && hostIn.channelPick)
    |=> (terminalReadyA_n == !$past(hostIn.wrData[0])))
    else $error("channel A terminal ready does not follow control bit 0");
  a_dtr_b_write: assert property ((mcrGo && !hostIn.channelPick)
    |=> (terminalReadyB_n == !$past(hostIn.wrData[0])))
    else $error("channel B terminal ready does not follow control bit 0");
  a_dtr_holds: assert property (!mcrGo |=> $stable({terminalReadyA_n, terminalReadyB_n}))
    else $error("terminal ready changed without a control write");
  a_reset_dma: assert property ($rose(rst_b) |-> (txDmaRequestA && !rxDmaRequestA))
    else $error("dma requests wrong after reset");
  cover property (rdGo);
  cover property (mcrGo && !hostIn.channelPick);
  cover property ($rose(rxDmaRequestA));
endmodule : dus_uart_checker

bind dus_uart dus_uart_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_dus_uart_checker (
  .clk_sys          (clk_sys),
  .rst_b            (rst_b),
  .hostIn           (hostIn),
  .dataOut          (dataOut),
  .dataOe_n         (dataOe_n),
  .terminalReadyA_n (terminalReadyA_n),
  .terminalReadyB_n (terminalReadyB_n),
  .rxDmaRequestA    (rxDmaRequestA),
  .txDmaRequestA    (txDmaRequestA)
);

// ### sim/dus_modem_model.sv
// model: far-end modem of both channels
// assumes: bench sets the modem line levels; serial lines looped back at the far end
`timescale 1ns/100ps
module dus_modem_model (
  input  wire logic       txA,
  input  wire logic       txB,
  input  wire logic [3:0] lineSet,
  output logic            rxA,
  output logic            rxB,
  output logic            clear_to_send_n_a_n,
  output logic            clear_to_send_n_b_n,
  output logic            cdA_n,
  output logic            cdB_n
);
  assign rxA = txA;
  assign rxB = txB;
  assign {cdB_n, cdA_n, clear_to_send_n_b_n, clear_to_send_n_a_n} = lineSet;
endmodule : dus_modem_model

// ### sim/tb.sv
// testbench: host bus accesses, modem lines and serial echo of both channels
// assumes: design inputs change at the falling edge, far-end modem model attached
`timescale 1ns/100ps
module tb;
  logic              clk_sys;
  logic              rst_b;
  dus_pkg::dus_bus_t bus;
  logic [3:0]        lineSet;
  logic [7:0]        dataOut;
  logic [7:0]        rdv;
  logic              dataOe_n;
  logic              sInA, sInB, sOutA, sOutB, clear_to_send_n_a_n, clear_to_send_n_b_n, cdA_n, cdB_n;
  logic              trA_n, trB_n, rxReqA, rxReqB, txReqA, txReqB;
  int                error_cnt;
  int                comparisons;

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  dus_uart #(.FIFO_DEPTH(16)) u_dus_uart (
    .clk_sys(clk_sys), .rst_b(rst_b), .hostIn(bus), .dataOut(dataOut), .dataOe_n(dataOe_n),
    .serialInA(sInA), .serialInB(sInB), .serialOutA(sOutA), .serialOutB(sOutB),
    .clearToSendA_n(clear_to_send_n_a_n), .clearToSendB_n(clear_to_send_n_b_n),
    .carrierDetectA_n(cdA_n), .carrierDetectB_n(cdB_n),
    .terminalReadyA_n(trA_n), .terminalReadyB_n(trB_n),
    .rxDmaRequestA(rxReqA), .rxDmaRequestB(rxReqB),
    .txDmaRequestA(txReqA), .txDmaRequestB(txReqB)
  );

  dus_modem_model u_dus_modem_model (
    .txA(sOutA), .txB(sOutB), .lineSet(lineSet), .rxA(sInA), .rxB(sInB),
    .clear_to_send_n_a_n(clear_to_send_n_a_n), .clear_to_send_n_b_n(clear_to_send_n_b_n), .cdA_n(cdA_n), .cdB_n(cdB_n)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic wr(input logic ch, input logic [2:0] rg, input logic [7:0] d,
                    input logic sel_n = 1'b0);
    @(negedge clk_sys);
    bus.cs_n = sel_n;
    bus.wr_n = 1'b0;
    bus.channelPick = ch;
    bus.regPick = rg;
    bus.wrData = d;
    @(negedge clk_sys);
    bus.cs_n = 1'b1;
    bus.wr_n = 1'b1;
    @(negedge clk_sys);
  endtask : wr

  task automatic rd(input logic ch, input logic [2:0] rg);
    @(negedge clk_sys);
    bus.cs_n = 1'b0;
    bus.rd_n = 1'b0;
    bus.channelPick = ch;
    bus.regPick = rg;
    repeat (2) @(negedge clk_sys);
    rdv = dataOut;
    chk("drive enable", {7'h00, dataOe_n}, 8'h00);
    bus.cs_n = 1'b1;
    bus.rd_n = 1'b1;
    @(negedge clk_sys);
  endtask : rd

  task automatic rchk(input string what, input logic ch, input logic [2:0] rg,
                      input logic [7:0] exp);
    rd(ch, rg);
    chk(what, rdv, exp);
  endtask : rchk

  task automatic wait_req(input logic ch);
    int n;
    n = 0;
    while ((ch ? rxReqA : rxReqB) !== 1'b1 && n < 1000)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 1000)
    begin
      error_cnt++;
      $display("BAD rx request expected 1 seen timeout");
      test_done();
    end
  endtask : wait_req
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    bus = dus_pkg::dus_bus_t'(15'h7000);
    lineSet = 4'hF;
    rst_b = 1'b0;
    error_cnt = 0;
    comparisons = 0;
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    chk("dtr pair", {6'h00, trA_n, trB_n}, 8'h03);
    chk("dma pair", {4'h0, txReqB, rxReqB, txReqA, rxReqA}, 8'h0A);
    // register pick and channel pick
    wr(1'b1, dus_pkg::REG_SPR, 8'h5A);
    wr(1'b0, dus_pkg::REG_SPR, 8'hA5);
    wr(1'b1, dus_pkg::REG_LCR, 8'h03);
    rchk("scratch a", 1'b1, dus_pkg::REG_SPR, 8'h5A);
    rchk("scratch b", 1'b0, dus_pkg::REG_SPR, 8'hA5);
    rchk("format a", 1'b1, dus_pkg::REG_LCR, 8'h03);
    rchk("format b", 1'b0, dus_pkg::REG_LCR, 8'h00);
    // deselected write and read
    wr(1'b1, dus_pkg::REG_SPR, 8'h11, 1'b1);
    rchk("scratch kept", 1'b1, dus_pkg::REG_SPR, 8'h5A);
    bus.rd_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("released", {7'h00, dataOe_n}, 8'h01);
    bus.rd_n = 1'b1;
    // terminal ready on channel A, channel B left off
    wr(1'b1, dus_pkg::REG_MCR, 8'h01);
    chk("dtr a on", {6'h00, trA_n, trB_n}, 8'h01);
    wr(1'b1, dus_pkg::REG_MCR, 8'h00);
    chk("dtr a off", {6'h00, trA_n, trB_n}, 8'h03);
    // modem status per channel
    lineSet = 4'h6;
    rchk("status a", 1'b1, dus_pkg::REG_MSR, 8'h10);
    rchk("status b", 1'b0, dus_pkg::REG_MSR, 8'h80);
    lineSet = 4'hF;
    // override: one write reaches both channels
    wr(1'b1, dus_pkg::REG_LCR, 8'h80);
    wr(1'b1, dus_pkg::REG_ALT, 8'h01);
    wr(1'b1, dus_pkg::REG_LCR, 8'h00);
    wr(1'b0, dus_pkg::REG_SPR, 8'h3C);
    rchk("both a", 1'b1, dus_pkg::REG_SPR, 8'h3C);
    rchk("both b", 1'b0, dus_pkg::REG_SPR, 8'h3C);
    wr(1'b0, dus_pkg::REG_LCR, 8'h80);
    wr(1'b0, dus_pkg::REG_ALT, 8'h00);
    // separate divisors, loopback on A over all four word lengths
    wr(1'b1, dus_pkg::REG_DATA, 8'h01);
    wr(1'b0, dus_pkg::REG_DATA, 8'h02);
    wr(1'b1, dus_pkg::REG_MCR, 8'h10);
    for (int i = 0; i < 4; i++)
    begin
      wr(1'b1, dus_pkg::REG_LCR, {3'h0, i[1], i[0], 1'b0, i[1:0]});
      wr(1'b1, dus_pkg::REG_DATA, 8'hFF);
      wait_req(1'b1);
      rd(1'b1, dus_pkg::REG_LSR);
      chk("line status", rdv & 8'h0F, 8'h01);
      rchk("echo a", 1'b1, dus_pkg::REG_DATA, 8'hFF >> (3 - i));
      chk("rx request a", {7'h00, rxReqA}, 8'h00);
    end
    // channel B out through the far end, held by clear-to-send
    wr(1'b0, dus_pkg::REG_LCR, 8'h03);
    wr(1'b0, dus_pkg::REG_DATA, 8'hA7);
    repeat (400) @(negedge clk_sys);
    chk("held by cts", {6'h00, txReqB, rxReqB}, 8'h00);
    lineSet = 4'hD;
    wait_req(1'b0);
    rchk("echo b", 1'b0, dus_pkg::REG_DATA, 8'hA7);
    // dma mode on A: receive request waits for four entries
    wr(1'b1, dus_pkg::REG_FCR, 8'h48);
    repeat (4) wr(1'b1, dus_pkg::REG_DATA, 8'h96);
    chk("tx request a", {7'h00, txReqA}, 8'h01);
    wait_req(1'b1);
    rchk("dma echo", 1'b1, dus_pkg::REG_DATA, 8'h96);
    chk("rx level a", {7'h00, rxReqA}, 8'h00);
    test_done();
  end
endmodule : tb
